/* File: pulse_dec_regs.vh */
// Constants for the algebraic pulse index decoder
// Behaviour
// - A 24-bit field is read as the raw joint value.
// - Raw value below the joint threshold is the combined index as is.
// - Otherwise fetch one bit, form raw*2+bit, subtract the threshold.
// - Combined index splits into quotient and remainder by second-track span.
// - Offset table gives pulsed-position count, sign index and joint index.
// - Joint index mod binomial is position index, quotient is multiplicity.
// - Positions come from subtracting binomials until the remainder drops.
// - Three pulses per index; extra pulses are three minus positions.
// - Extra-pulse locations: upward scan, keep last value leaving room.
// - Counts start at one per position, plus one per extra location.
// - Positions, counts and signs give the full pulse pattern per track.
// - Multi-track parameters are looked up by each track's pulse count.
// - Shared high field unpacks by chained modulo and division per track.
// - Each track's high part joins its low part into the track index.
// - The received index fixes positions and signed pulse amplitudes.
// - Sharpening applies only when the integer pitch lag is below 64.
// - Periodicity feedback coefficient is 0.85, with a tilt stage.
// - Tilt clamps to 0.28..0.56 at the two high rates, else 0.0..0.5.
// - Formant weighting 0.75/0.9 at 12800 Hz, 0.8/0.92 at 16000 Hz.
`ifndef PULSE_DEC_REGS_VH
`define PULSE_DEC_REGS_VH

`define RAW_BITS      24
`define JOINT_THR     25'h0371c00
`define PULSES_Q      3
`define PPT_Q         2
`define TRACK_LEN     16
`define W2_SPAN       13'h1560
`define OFF_N2        13'h0020
`define OFF_N3        13'h03e0
`define C_M_1         13'h0010
`define C_M_2         13'h0078
`define C_M_3         13'h0230
`define SUBFR_LEN     8'h40
`define PERIOD_GAIN   16'h6ccd
`define TILT_MIN_HI   16'h23d7
`define TILT_MAX_HI   16'h47ae
`define TILT_MIN_LO   16'h0000
`define TILT_MAX_LO   16'h4000
`define ETA1_12K8     16'h6000
`define ETA2_12K8     16'h7333
`define ETA1_16K      16'h6666
`define ETA2_16K      16'h75c3
`define HB_BITS       4'h2
`define HB_RANGE      16'h0003
`define FIFO_W        8
`define FIFO_D        8

`endif

/* File: pulse_fifo.v */
// Small FIFO with a registered output stage
`timescale 1ns/100ps
`default_nettype none
module pulse_fifo #(
    parameter W  = 8,
    parameter D  = 8,
    parameter AW = 3
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rstn,
    // Fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // Drain side
    output reg          out_valid_r,
    input  wire         out_ready,
    output reg  [W-1:0] out_data_r,
    output wire         empty
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire push = in_valid && in_ready;
    wire pop  = (cnt_r != 0) && (!out_valid_r || out_ready);

    assign in_ready = (cnt_r != D[AW:0]);
    assign empty    = (cnt_r == 0) && !out_valid_r;

    always @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r        <= {AW{1'b0}};
            rp_r        <= {AW{1'b0}};
            cnt_r       <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
            out_data_r  <= {W{1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r       <= rp_r + 1'b1;
                out_data_r <= mem[rp_r];
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
            if (pop) begin
                out_valid_r <= 1'b1;
            end else if (out_ready) begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule // pulse_fifo
`default_nettype wire

/* File: pulse_index_decoder.v */
// Algebraic pulse index decoder with pre-filter parameters
`timescale 1ns/100ps
`default_nettype none
`include "pulse_dec_regs.vh"
module pulse_index_decoder (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Subframe request
    input  wire        start,
    input  wire [23:0] raw_joint,
    output reg         more_bit_req_r,
    input  wire        more_bit_valid,
    input  wire        more_bit,
    // Multi-track fields
    input  wire [15:0] final_index_0,
    input  wire [15:0] final_index_1,
    input  wire [15:0] final_index_2,
    input  wire [15:0] final_index_3,
    input  wire [15:0] shared_high_field,
    input  wire [2:0]  pulses_0,
    input  wire [2:0]  pulses_1,
    input  wire [2:0]  pulses_2,
    input  wire [2:0]  pulses_3,
    // Pre-filter controls
    input  wire [7:0]  pitch_lag_int,
    input  wire [15:0] prev_voicing,
    input  wire        rate_high,
    input  wire        sr_16k,
    input  wire        formant_req,
    // Pulse pattern stream
    output wire        pulse_valid,
    input  wire        pulse_ready,
    output wire [7:0]  pulse_data,
    // Results
    output reg         busy_r,
    output reg         done_r,
    output reg  [15:0] track_index_0_r,
    output reg  [15:0] track_index_1_r,
    output reg  [15:0] track_index_2_r,
    output reg  [15:0] track_index_3_r,
    output reg         sharpen_en_r,
    output reg  [15:0] period_gain_r,
    output reg  [15:0] tilt_r,
    output reg         formant_en_r,
    output reg  [15:0] eta1_r,
    output reg  [15:0] eta2_r
);
    localparam [8:0] S_IDLE = 9'h001, S_FETCH = 9'h002, S_SPLIT = 9'h004,
                     S_OFFS = 9'h008, S_POS = 9'h010, S_MULT = 9'h020,
                     S_EMIT = 9'h040, S_MT = 9'h080, S_DONE = 9'h100;

    reg [8:0]  st_r;
    reg [24:0] joint_r;
    reg [12:0] ind1_r, ind2_r;
    reg        tr_r;
    reg [1:0]  n_r;
    reg [2:0]  sgn_r;
    reg [12:0] rem_r;
    reg [12:0] i3_r;
    reg [1:0]  k_r;
    reg [3:0]  p_r;
    reg [11:0] pos_r;
    reg [5:0]  cnt_r;
    reg [1:0]  h_r, q_r, qs_r, best_r;
    reg [12:0] bestd_r;
    reg [1:0]  e_r;
    reg [24:0] joint_nxt;

    // Binomial for the small orders used here
    function integer comb;
        input integer n;
        input integer k;
        begin
            if (n < k || n < 0)
                comb = 0;
            else if (k == 0)
                comb = 1;
            else if (k == 1)
                comb = n;
            else
                comb = (n * (n - 1)) / 2;
        end
    endfunction

    // Per-count track parameters: low field width
    function [3:0] low_bits;
        input [2:0] pc;
        begin
            case (pc)
                3'd1:    low_bits = 4'd4;
                3'd2:    low_bits = 4'd8;
                3'd3:    low_bits = 4'd11;
                default: low_bits = 4'd12;
            endcase
        end
    endfunction

    wire        fifo_in_ready;
    wire        fifo_empty;
    wire [1:0]  dn = 2'd3 - n_r;
    wire [24:0] quo_w = joint_r / `W2_SPAN;
    wire [24:0] mod_w = joint_r % `W2_SPAN;
    wire        emit_now = st_r[6] && fifo_in_ready;

    // Offset table lookup for the current track
    reg [12:0] tind, loc, i23, cmn;
    reg [1:0]  nsel;
    always @* begin
        tind = tr_r ? ind2_r : ind1_r;
        if (tind >= `OFF_N3) begin
            nsel = 2'd3;
            loc  = tind - `OFF_N3;
            cmn  = `C_M_3;
        end else if (tind >= `OFF_N2) begin
            nsel = 2'd2;
            loc  = tind - `OFF_N2;
            cmn  = `C_M_2;
        end else begin
            nsel = 2'd1;
            loc  = tind;
            cmn  = `C_M_1;
        end
        i23 = loc >> nsel;
    end

    // One step of position unranking and multiplicity scan
    reg [12:0] cpos, dq;
    integer    ci, cj, ck;
    always @* begin
        ci   = comb(`TRACK_LEN - 1 - p_r, n_r - 1 - k_r);
        cpos = ci[12:0];
        cj   = comb(`PPT_Q - h_r - qs_r, dn);
        ck   = comb(`PPT_Q - h_r - q_r, dn);
        dq   = cj[12:0] - ck[12:0];
    end

    // Multi-track high field unpacking
    reg [31:0] acc, md;
    reg [15:0] hi0, hi1, hi2, hi3;
    reg [15:0] hpart0, hpart1, hpart2, hpart3;
    always @* begin
        hpart0 = final_index_0 >> low_bits(pulses_0);
        hpart1 = final_index_1 >> low_bits(pulses_1);
        hpart2 = final_index_2 >> low_bits(pulses_2);
        hpart3 = final_index_3 >> low_bits(pulses_3);
        acc = {16'h0000, shared_high_field};
        acc = (acc << `HB_BITS) | {16'h0000, hpart3};
        acc = (acc << `HB_BITS) | {16'h0000, hpart2};
        md  = acc % `HB_RANGE;
        hi3 = md[15:0];
        acc = acc / `HB_RANGE;
        acc = (acc << `HB_BITS) | {16'h0000, hpart1};
        md  = acc % `HB_RANGE;
        hi2 = md[15:0];
        acc = acc / `HB_RANGE;
        acc = (acc << `HB_BITS) | {16'h0000, hpart0};
        md  = acc % `HB_RANGE;
        hi1 = md[15:0];
        acc = acc / `HB_RANGE;
        hi0 = acc[15:0];
        if (raw_joint < `JOINT_THR)
            joint_nxt = {1'b0, raw_joint};
        else
            joint_nxt = 25'h0;
    end

    // Low part masks, joined with the unpacked high parts
    function [15:0] join_idx;
        input [15:0] hi;
        input [15:0] fin;
        input [2:0]  pc;
        reg   [15:0] mask;
        begin
            mask     = (16'h0001 << low_bits(pc)) - 16'h0001;
            join_idx = (hi << low_bits(pc)) | (fin & mask);
        end
    endfunction

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= S_IDLE;
            joint_r <= 25'h0;
            ind1_r <= 13'h0;
            ind2_r <= 13'h0;
            tr_r <= 1'b0;
            n_r <= 2'd1;
            sgn_r <= 3'h0;
            rem_r <= 13'h0;
            i3_r <= 13'h0;
            k_r <= 2'd0;
            p_r <= 4'h0;
            pos_r <= 12'h0;
            cnt_r <= 6'h0;
            h_r <= 2'd0;
            q_r <= 2'd0;
            qs_r <= 2'd0;
            best_r <= 2'd0;
            bestd_r <= 13'h0;
            e_r <= 2'd0;
            more_bit_req_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            track_index_0_r <= 16'h0;
            track_index_1_r <= 16'h0;
            track_index_2_r <= 16'h0;
            track_index_3_r <= 16'h0;
            sharpen_en_r <= 1'b0;
            period_gain_r <= 16'h0;
            tilt_r <= 16'h0;
            formant_en_r <= 1'b0;
            eta1_r <= 16'h0;
            eta2_r <= 16'h0;
        end else begin
            done_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (start) begin
                        busy_r  <= 1'b1;
                        tr_r    <= 1'b0;
                        joint_r <= joint_nxt;
                        sharpen_en_r  <= (pitch_lag_int < `SUBFR_LEN);
                        period_gain_r <= `PERIOD_GAIN;
                        if (rate_high)
                            tilt_r <= (prev_voicing < `TILT_MIN_HI) ?
                                `TILT_MIN_HI : (prev_voicing > `TILT_MAX_HI) ?
                                `TILT_MAX_HI : prev_voicing;
                        else
                            tilt_r <= (prev_voicing > `TILT_MAX_LO) ?
                                `TILT_MAX_LO : prev_voicing;
                        formant_en_r <= formant_req;
                        eta1_r <= sr_16k ? `ETA1_16K : `ETA1_12K8;
                        eta2_r <= sr_16k ? `ETA2_16K : `ETA2_12K8;
                        if (raw_joint < `JOINT_THR) begin
                            st_r <= S_SPLIT;
                        end else begin
                            joint_r <= {1'b0, raw_joint};
                            more_bit_req_r <= 1'b1;
                            st_r <= S_FETCH;
                        end
                    end
                end
                S_FETCH: begin
                    if (more_bit_valid) begin
                        more_bit_req_r <= 1'b0;
                        joint_r <= {joint_r[23:0], more_bit} -
                                   `JOINT_THR;
                        st_r <= S_SPLIT;
                    end
                end
                S_SPLIT: begin
                    ind1_r <= quo_w[12:0];
                    ind2_r <= mod_w[12:0];
                    st_r   <= S_OFFS;
                end
                S_OFFS: begin
                    n_r   <= nsel;
                    sgn_r <= loc[2:0] & ((3'h1 << nsel) - 3'h1);
                    rem_r <= i23 % cmn;
                    i3_r  <= i23 / cmn;
                    cnt_r <= (nsel == 2'd3) ? 6'h15 :
                             (nsel == 2'd2) ? 6'h05 : 6'h01;
                    pos_r <= 12'h0;
                    k_r <= 2'd0;
                    p_r <= 4'h0;
                    st_r <= S_POS;
                end
                S_POS: begin
                    p_r <= p_r + 4'h1;
                    if (rem_r < cpos) begin
                        pos_r[k_r*4 +: 4] <= p_r;
                        k_r <= k_r + 2'd1;
                        if (k_r + 2'd1 == n_r) begin
                            h_r <= 2'd0;
                            q_r <= 2'd0;
                            qs_r <= 2'd0;
                            best_r <= 2'd0;
                            bestd_r <= 13'h0;
                            st_r <= (dn == 2'd0) ? S_EMIT : S_MULT;
                        end
                    end else begin
                        rem_r <= rem_r - cpos;
                    end
                end
                S_MULT: begin
                    if (i3_r >= dq) begin
                        best_r  <= q_r;
                        bestd_r <= dq;
                    end
                    if (q_r + 2'd1 >= n_r) begin
                        if (i3_r >= dq) begin
                            cnt_r[q_r*2 +: 2] <= cnt_r[q_r*2 +: 2] + 2'd1;
                            i3_r <= i3_r - dq;
                            qs_r <= q_r;
                            q_r  <= q_r;
                        end else begin
                            cnt_r[best_r*2 +: 2] <=
                                cnt_r[best_r*2 +: 2] + 2'd1;
                            i3_r <= i3_r - bestd_r;
                            qs_r <= best_r;
                            q_r  <= best_r;
                        end
                        bestd_r <= 13'h0;
                        h_r <= h_r + 2'd1;
                        if (h_r + 2'd1 == dn) begin
                            e_r <= 2'd0;
                            st_r <= S_EMIT;
                        end
                    end else begin
                        q_r <= q_r + 2'd1;
                    end
                end
                S_EMIT: begin
                    if (fifo_in_ready) begin
                        e_r <= e_r + 2'd1;
                        if (e_r + 2'd1 == n_r) begin
                            e_r  <= 2'd0;
                            tr_r <= 1'b1;
                            st_r <= tr_r ? S_MT : S_OFFS;
                        end
                    end
                end
                S_MT: begin
                    track_index_0_r <= join_idx(hi0, final_index_0,
                                                pulses_0);
                    track_index_1_r <= join_idx(hi1, final_index_1, pulses_1);
                    track_index_2_r <= join_idx(hi2, final_index_2, pulses_2);
                    track_index_3_r <= join_idx(hi3, final_index_3, pulses_3);
                    st_r <= S_DONE;
                end
                S_DONE: begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    st_r   <= S_IDLE;
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    // Entry: track, position, count, sign; the sign makes it signed
    wire [7:0] entry = {tr_r, pos_r[e_r*4 +: 4], cnt_r[e_r*2 +: 2],
                        sgn_r[e_r]};

    pulse_fifo #(
        .W  (`FIFO_W),
        .D  (`FIFO_D),
        .AW (3)
    ) u_fifo (
        .clk         (clk),
        .rstn        (rstn),
        .in_valid    (emit_now),
        .in_ready    (fifo_in_ready),
        .in_data     (entry),
        .out_valid_r (pulse_valid),
        .out_ready   (pulse_ready),
        .out_data_r  (pulse_data),
        .empty       (fifo_empty)
    );
endmodule // pulse_index_decoder
`default_nettype wire

/* File: pulse_dec_monitor.sv */
// Port-level checker for the pulse index decoder
`timescale 1ns/100ps
`default_nettype none
`include "pulse_dec_regs.vh"
module pulse_dec_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Request side
    input wire logic        start,
    input wire logic [23:0] raw_joint,
    input wire logic        more_bit_req_r,
    input wire logic        more_bit_valid,
    input wire logic [7:0]  pitch_lag_int,
    input wire logic        rate_high,
    input wire logic        formant_req,
    // Results
    input wire logic        pulse_valid,
    input wire logic        pulse_ready,
    input wire logic [7:0]  pulse_data,
    input wire logic        busy_r,
    input wire logic        done_r,
    input wire logic        sharpen_en_r,
    input wire logic [15:0] period_gain_r,
    input wire logic [15:0] tilt_r,
    input wire logic        formant_en_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_take;
        start && !busy_r;
    endsequence
    sequence s_take_low;
        s_take ##0 (raw_joint < `JOINT_THR);
    endsequence
    sequence s_take_high;
        s_take ##0 (raw_joint >= `JOINT_THR);
    endsequence

    property p_done_one;
        done_r |=> !done_r;
    endproperty
    a_done_one: assert property (p_done_one)
        else $error("done held past one cycle");
    property p_done_bound;
        s_take |=> busy_r ##[0:1000] done_r;
    endproperty
    a_done_bound: assert property (p_done_bound)
        else $error("subframe not finished in time");
    property p_done_idle;
        done_r |-> !busy_r;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("done while still busy");
    property p_no_extra;
        s_take_low |=> !more_bit_req_r [*4];
    endproperty
    a_no_extra: assert property (p_no_extra)
        else $error("extra bit asked below threshold");
    property p_extra;
        s_take_high |=> more_bit_req_r;
    endproperty
    a_extra: assert property (p_extra)
        else $error("extra bit not asked");
    property p_req_hold;
        more_bit_req_r && !more_bit_valid |=> more_bit_req_r;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("bit request dropped early");
    property p_req_drop;
        more_bit_req_r && more_bit_valid |=> !more_bit_req_r;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("bit request kept after bit");
    property p_sharpen;
        s_take |=> sharpen_en_r == ($past(pitch_lag_int) < 8'h40);
    endproperty
    a_sharpen: assert property (p_sharpen)
        else $error("sharpening enable wrong");
    property p_gain;
        sharpen_en_r |-> period_gain_r == `PERIOD_GAIN;
    endproperty
    a_gain: assert property (p_gain)
        else $error("periodicity gain wrong");
    property p_tilt;
        s_take |=> ($past(rate_high)
            ? (tilt_r >= `TILT_MIN_HI && tilt_r <= `TILT_MAX_HI)
            : (tilt_r <= `TILT_MAX_LO));
    endproperty
    a_tilt: assert property (p_tilt)
        else $error("tilt out of bounds");
    property p_formant;
        s_take |=> formant_en_r == $past(formant_req);
    endproperty
    a_formant: assert property (p_formant)
        else $error("formant enable wrong");
    property p_stream_hold;
        pulse_valid && !pulse_ready |=> pulse_valid && $stable(pulse_data);
    endproperty
    a_stream_hold: assert property (p_stream_hold)
        else $error("stream entry lost while stalled");
endmodule // pulse_dec_monitor

bind pulse_index_decoder pulse_dec_monitor i_mon (
    .clk(clk), .rstn(rstn), .start(start), .raw_joint(raw_joint),
    .more_bit_req_r(more_bit_req_r), .more_bit_valid(more_bit_valid),
    .pitch_lag_int(pitch_lag_int), .rate_high(rate_high),
    .formant_req(formant_req), .pulse_valid(pulse_valid),
    .pulse_ready(pulse_ready), .pulse_data(pulse_data), .busy_r(busy_r),
    .done_r(done_r), .sharpen_en_r(sharpen_en_r),
    .period_gain_r(period_gain_r), .tilt_r(tilt_r),
    .formant_en_r(formant_en_r)
);
`default_nettype wire

/* File: bit_reader_model.sv */
// Behavioural bitstream reader answering extra-bit requests
`timescale 1ns/100ps
`default_nettype none
module bit_reader_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Request side
    input  wire logic       req,
    input  wire logic [3:0] delay,
    input  wire logic       value,
    output logic            bit_valid,
    output logic            bit_out
);
    int cnt;
    initial begin
        bit_valid = 1'b0;
        bit_out = 1'b0;
        cnt = 0;
    end
    // Outside an offer the data line toggles so stale bits cannot pass
    always @(posedge clk) begin
        #1;
        if (!rstn || !req || bit_valid) begin
            bit_valid = 1'b0;
            cnt = 0;
            bit_out = ~bit_out;
        end else if (cnt >= delay) begin
            bit_valid = 1'b1;
            bit_out = value;
        end else begin
            cnt++;
            bit_out = ~bit_out;
        end
    end
endmodule // bit_reader_model
`default_nettype wire

/* File: algebraic_pulse_index_decoder_bench.sv */
// Self-checking bench for the pulse index decoder
`timescale 1ns/100ps
`default_nettype none
`include "pulse_dec_regs.vh"
module algebraic_pulse_index_decoder_bench;
    logic        clk = 0, rstn = 0, start = 0, pulse_ready = 1;
    logic        more_bit_valid, more_bit, more_bit_req_r, pulse_valid;
    logic        rate_high = 0, sr_16k = 0, formant_req = 0, value = 0;
    logic [23:0] raw_joint = 0;
    logic [15:0] fin [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] shared = 0, prev_voicing = 0, tilt_r, gain_r, e1, e2;
    logic [15:0] ti0, ti1, ti2, ti3;
    logic [7:0]  pitch_lag_int = 0, pulse_data;
    logic [3:0]  delay = 0;
    logic [2:0]  pc = 3'h1;
    logic        busy_r, done_r, sharpen_en_r, formant_en_r;
    logic [7:0]  got [$];
    int          failures = 0, cmp_count = 0, req_cnt = 0;

    always #20 clk = ~clk;
    always @(posedge clk) if (pulse_valid === 1'b1 && pulse_ready)
        got.push_back(pulse_data);
    always @(posedge more_bit_req_r) req_cnt++;

    pulse_index_decoder i_dut (
        .clk(clk), .rstn(rstn), .start(start), .raw_joint(raw_joint),
        .more_bit_req_r(more_bit_req_r), .more_bit_valid(more_bit_valid),
        .more_bit(more_bit), .final_index_0(fin[0]), .final_index_1(fin[1]),
        .final_index_2(fin[2]), .final_index_3(fin[3]),
        .shared_high_field(shared), .pulses_0(pc), .pulses_1(pc),
        .pulses_2(pc), .pulses_3(pc), .pitch_lag_int(pitch_lag_int),
        .prev_voicing(prev_voicing), .rate_high(rate_high),
        .sr_16k(sr_16k), .formant_req(formant_req),
        .pulse_valid(pulse_valid), .pulse_ready(pulse_ready),
        .pulse_data(pulse_data), .busy_r(busy_r), .done_r(done_r),
        .track_index_0_r(ti0), .track_index_1_r(ti1),
        .track_index_2_r(ti2), .track_index_3_r(ti3),
        .sharpen_en_r(sharpen_en_r), .period_gain_r(gain_r),
        .tilt_r(tilt_r), .formant_en_r(formant_en_r), .eta1_r(e1),
        .eta2_r(e2)
    );
    bit_reader_model i_reader (
        .clk(clk), .rstn(rstn), .req(more_bit_req_r), .delay(delay),
        .value(value), .bit_valid(more_bit_valid), .bit_out(more_bit)
    );

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One subframe; a second start is tried while busy when again is set
    task automatic run(input logic [23:0] raw, input int stall,
                       input bit again);
        int n;
        n = 0;
        got.delete();
        raw_joint = raw;
        start = 1;
        @(posedge clk);
        #1 start = 0;
        pulse_ready = (stall == 0);
        while (done_r !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1 n++;
            if (n == stall) pulse_ready = 1;
            if (again) start = (n == 3);
        end
        start = 0;
        pulse_ready = 1;
        check("done seen", n < 2000, 1);
        repeat (12) @(posedge clk);
        #1 check("idle after done", busy_r, 0);
    endtask

    task automatic check_zero_entries();
        check("entry count", got.size(), 2);
        if (got.size() == 2) begin
            check("first track entry", got[0], 8'h06);
            check("second track entry", got[1], 8'h86);
        end
    endtask

    task automatic t_reset();
        check("busy at reset", busy_r, 0);
        check("done at reset", done_r, 0);
        check("stream at reset", pulse_valid, 0);
        check("req at reset", more_bit_req_r, 0);
        raw_joint = 24'hffffff;
        start = 1;
        @(posedge clk);
        #1 start = 0;
        repeat (3) @(posedge clk);
        #1 rstn = 0;
        #1 check("busy in reset", busy_r, 0);
        check("req in reset", more_bit_req_r, 0);
        @(posedge clk);
        #1 rstn = 1;
    endtask

    task automatic t_prefilter();
        logic [7:0]  lag [4] = '{8'h3f, 8'h40, 8'h00, 8'hff};
        logic [15:0] voi [4] = '{16'h7fff, 16'h0000, 16'h7fff, 16'h1000};
        logic [15:0] tl [4] = '{`TILT_MAX_HI, `TILT_MIN_HI, `TILT_MAX_LO,
                                16'h1000};
        logic [3:0]  rh = 4'b0011, s16 = 4'b0110, fr = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            pitch_lag_int = lag[i];
            prev_voicing = voi[i];
            rate_high = rh[i];
            sr_16k = s16[i];
            formant_req = fr[i];
            run(24'h000000, 0, 0);
            check_zero_entries();
            check("sharpen", sharpen_en_r, lag[i] < 8'h40);
            if (lag[i] < 8'h40)
                check("period gain", gain_r, `PERIOD_GAIN);
            check("tilt", tilt_r, tl[i]);
            check("formant enable", formant_en_r, fr[i]);
            if (fr[i]) begin
                check("eta1", e1, sr_16k ? `ETA1_16K : `ETA1_12K8);
                check("eta2", e2, sr_16k ? `ETA2_16K : `ETA2_12K8);
            end
            check("track0", ti0, 0);
            check("track3", ti3, 0);
        end
    endtask

    task automatic t_extra_bit();
        int r;
        r = req_cnt;
        delay = 4'h5;
        value = 1;
        run(`JOINT_THR, 0, 0);
        check("one slow request", req_cnt - r, 1);
        delay = 4'h0;
        value = 0;
        fin = '{16'h1234, 16'h0fff, 16'h8001, 16'hffff};
        shared = 16'h5a5a;
        pc = 3'h3;
        run(24'hffffff, 0, 0);
        check("one prompt request", req_cnt - r, 2);
        check("mt track0", ti0, 16'h0234);
        check("mt track1", ti1, 16'h17ff);
        check("mt track2", ti2, 16'h0801);
        check("mt track3", ti3, 16'h17ff);
        check("request released", more_bit_req_r, 0);
        run(24'h371bff, 0, 0);
        check("no request below threshold", req_cnt - r, 2);
    endtask

    // Stalled stream and a refused start must not disturb the result
    task automatic t_stall_busy();
        fin = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        shared = 0;
        run(24'h000000, 30, 1);
        check_zero_entries();
    endtask

    initial begin
        #(40 * 20000);
        failures++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk);
        #1 rstn = 1;
        t_reset();
        t_prefilter();
        t_extra_bit();
        t_stall_busy();
        test_done();
    end
endmodule // algebraic_pulse_index_decoder_bench
`default_nettype wire
